// [verilog/sbsi_consts.vh]
// Purpose: Shared constants of the synchronous burst static RAM interface
// Assumes: Included by bare name from every design file
// Notes:   Definitions only
`ifndef SBSI_CONSTS_VH
`define SBSI_CONSTS_VH

// ********************************
// Geometry
// ********************************
`define SBSI_LANE_W      9
`define SBSI_LANES       4
`define SBSI_ADDR_W      10
`define SBSI_BURST_W     2
`define SBSI_FIFO_DEPTH  32
`define SBSI_FIFO_AW     5

// ********************************
// Late-write latency in clock edges
// ********************************
`define SBSI_WLAT_PIPE   2
`define SBSI_WLAT_FLOW   1

// ********************************
// Cycle kinds
// ********************************
`define SBSI_OP_IDLE     2'h0
`define SBSI_OP_READ     2'h1
`define SBSI_OP_WRITE    2'h2

`endif

// [verilog/sbsi_fifo.v]
// Purpose: Write buffer between the late-write capture and the array
// Assumes: Single clock, synchronous active-low reset
// Notes:   in_ready is low only when full; a pop and push may share a cycle
`timescale 1ns/1ns
`default_nettype none
`include "sbsi_consts.vh"

module sbsi_fifo #(
	parameter W     = 50,
	parameter DEPTH = `SBSI_FIFO_DEPTH,
	parameter AW    = `SBSI_FIFO_AW
) (
	input  wire         ref_clk,
	input  wire         reset_n,
	input  wire         in_valid,
	output wire         in_ready,
	input  wire [W-1:0] in_data,
	output wire         out_valid,
	input  wire         out_ready,
	output wire [W-1:0] out_data
);

	reg [W-1:0]  store_r [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_r;
	reg [AW-1:0] rd_ptr_r;
	reg [AW:0]   count_r;

	// Explicit last index so depths that are not a power of two wrap correctly
	localparam [31:0] LAST_IDX = DEPTH - 1;

	wire push = in_valid & in_ready;
	wire pop  = out_valid & out_ready;

	assign in_ready  = (count_r != DEPTH[AW:0]);
	assign out_valid = (count_r != {(AW+1){1'b0}});
	assign out_data  = store_r[rd_ptr_r];

	always @(posedge ref_clk) begin
		if (push) begin
			store_r[wr_ptr_r] <= in_data;
		end
	end

	always @(posedge ref_clk) begin
		if (!reset_n) begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			count_r  <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == LAST_IDX[AW-1:0]) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == LAST_IDX[AW-1:0]) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
			end
			if (push && !pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop && !push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end

endmodule // sbsi_fifo
`default_nettype wire

// [verilog/sbsi_burst.v]
// Purpose: Two-bit burst address counter, linear or interleaved
// Assumes: Order select held static during operation
// Notes:   next_low is the address of the following beat
`timescale 1ns/1ns
`default_nettype none
`include "sbsi_consts.vh"

module sbsi_burst (
	input  wire                     ref_clk,
	input  wire                     reset_n,
	input  wire                     load,
	input  wire                     step,
	input  wire [`SBSI_BURST_W-1:0] start_in,
	input  wire                     burst_order_sel_n,
	output wire [`SBSI_BURST_W-1:0] next_low
);

	reg  [`SBSI_BURST_W-1:0] start_r;
	reg  [`SBSI_BURST_W-1:0] cnt_r;
	wire [`SBSI_BURST_W-1:0] cnt_inc = cnt_r + 1'b1;

	// Both orders wrap inside the four-word group
	assign next_low = burst_order_sel_n ? (start_r ^ cnt_inc) : (start_r + cnt_inc); // [RQ10] [RQ18]

	always @(posedge ref_clk) begin
		if (!reset_n) begin
			start_r <= {`SBSI_BURST_W{1'b0}};
			cnt_r   <= {`SBSI_BURST_W{1'b0}};
		end else if (load) begin
			start_r <= start_in;
			cnt_r   <= {`SBSI_BURST_W{1'b0}};
		end else if (step) begin
			cnt_r   <= cnt_inc; // [RQ16]
		end
	end

endmodule // sbsi_burst
`default_nettype wire

// [verilog/sbsi_core.v]
// Purpose: Synchronous burst static RAM with late write and no turnaround
// Assumes: Inputs synchronous to ref_clk; mode straps held static
// Notes:   dq_oe and power_down are gated by asynchronous inputs on purpose
`timescale 1ns/1ns
`default_nettype none
`include "sbsi_consts.vh"

// Contract
// RQ1: Inputs sampled only at rising clock edge
// RQ2: Output enable tristates outputs asynchronously
// RQ3: Sleep request powers down without clock
// RQ4: Writes start on edge, self-timed internally
// RQ5: Pipelined reads registered, driven next edge
// RQ6: Pipelined or flow-through read selectable
// RQ7: Write data two or one cycles late
// RQ8: Reads and writes alternate without idle
// RQ9: Per 9-bit lane active-low byte writes
// RQ10: Burst order linear or interleaved
// RQ11: Host keeps burst order static
// RQ12: Three chip selects, all must assert
// RQ13: Selects one and three low, two high
// RQ14: Flow-through select low means flow-through
// RQ15: Write enable low marks write cycle
// RQ16: Clock enable low; advance steps counter
// RQ17: Clock enable high freezes all state; the write buffer still drains into the array
// RQ18: Burst wraps in four-word group
module sbsi_core #(
	parameter LANE_W = `SBSI_LANE_W,
	parameter LANES  = `SBSI_LANES,
	parameter ADDR_W = `SBSI_ADDR_W,
	parameter DEPTH  = `SBSI_FIFO_DEPTH
) (
	input  wire                      ref_clk,
	input  wire                      reset_n,
	input  wire [ADDR_W-1:0]         address,
	input  wire                      chip_sel_a_n,
	input  wire                      chip_sel_b,
	input  wire                      chip_sel_c_n,
	input  wire                      write_en_n,
	input  wire                      clock_en_n,
	input  wire                      burst_advance,
	input  wire [LANES-1:0]          byte_write_n,
	input  wire [LANES*LANE_W-1:0]   dq_in,
	input  wire                      output_en_n,
	input  wire                      sleep_req,
	input  wire                      flow_through_sel_n,
	input  wire                      burst_order_sel_n,
	output wire [LANES*LANE_W-1:0]   dq_out,
	output wire                      dq_oe,
	output wire                      power_down,
	output wire                      wr_buf_ready,
	output wire                      write_dropped
);

	localparam DATA_W = LANES * LANE_W;
	localparam CMD_W  = ADDR_W + LANES + DATA_W;
	localparam WORDS  = 1 << ADDR_W;

	// ********************************
	// Sampling qualifiers
	// ********************************
	// Sleep turns the edge into a no-op; a high clock enable does too, except that the write buffer keeps draining
	wire active   = ~clock_en_n & ~sleep_req;                      // [RQ17] [RQ3]
	wire selected = ~chip_sel_a_n & chip_sel_b & ~chip_sel_c_n;    // [RQ12] [RQ13]
	wire flow     = ~flow_through_sel_n;                           // [RQ14] [RQ6]

	// ********************************
	// Pipeline state
	// ********************************
	reg  [1:0]                 op_last_r;
	reg  [ADDR_W-1:0]          base_addr_r;
	reg  [1:0]                 a1_op_r;
	reg  [ADDR_W-1:0]          a1_addr_r;
	reg  [1:0]                 a2_op_r;
	reg  [ADDR_W-1:0]          a2_addr_r;
	reg  [DATA_W-1:0]          dq_out_r;
	reg                        dq_drive_r;
	reg                        write_dropped_r;

	reg  [1:0]                 op_nxt;
	reg  [ADDR_W-1:0]          addr_nxt;
	reg                        burst_load;
	reg                        burst_step;
	wire [`SBSI_BURST_W-1:0]   burst_low;

	// ********************************
	// Burst counter
	// ********************************
	sbsi_burst u_burst (
		.ref_clk           (ref_clk),
		.reset_n           (reset_n),
		.load              (burst_load & active),
		.step              (burst_step & active),
		.start_in          (address[`SBSI_BURST_W-1:0]),
		.burst_order_sel_n (burst_order_sel_n),
		.next_low          (burst_low)
	);

	// ********************************
	// Burst address
	// ********************************
	// Upper bits stay with the group; only the low two bits move
	wire [ADDR_W-1:0] burst_addr = {base_addr_r[ADDR_W-1:`SBSI_BURST_W], burst_low}; // [RQ18]

	// ********************************
	// Cycle decode
	// ********************************
	// Advance repeats the last cycle kind; after a deselect it does nothing
	always @* begin
		op_nxt     = `SBSI_OP_IDLE;
		addr_nxt   = address;
		burst_load = 1'b0;
		burst_step = 1'b0;
		if (burst_advance) begin
			if (op_last_r != `SBSI_OP_IDLE) begin
				op_nxt     = op_last_r;
				addr_nxt   = burst_addr;                                      // [RQ18]
				burst_step = 1'b1;                                            // [RQ16]
			end
		end else if (selected) begin
			op_nxt     = write_en_n ? `SBSI_OP_READ : `SBSI_OP_WRITE;           // [RQ15]
			burst_load = 1'b1;
		end
	end

	always @(posedge ref_clk) begin
		if (!reset_n) begin
			op_last_r   <= `SBSI_OP_IDLE;
			base_addr_r <= {ADDR_W{1'b0}};
			a1_op_r     <= `SBSI_OP_IDLE;
			a1_addr_r   <= {ADDR_W{1'b0}};
			a2_op_r     <= `SBSI_OP_IDLE;
			a2_addr_r   <= {ADDR_W{1'b0}};
		end else if (active) begin                                          // [RQ1] [RQ17]
			op_last_r <= op_nxt;
			if (burst_load) begin
				base_addr_r <= address;
			end
			// Any kind may follow any kind; no idle slot is needed
			a1_op_r   <= op_nxt;                                            // [RQ8]
			a1_addr_r <= addr_nxt;
			a2_op_r   <= a1_op_r;
			a2_addr_r <= a1_addr_r;
		end
	end

	// ********************************
	// Late-write capture
	// ********************************
	// Data lags the address by one edge in flow-through, two in pipelined
	wire              push_req  = active & (flow ? (a1_op_r == `SBSI_OP_WRITE)
	                                             : (a2_op_r == `SBSI_OP_WRITE)); // [RQ7]
	wire [ADDR_W-1:0] push_addr = flow ? a1_addr_r : a2_addr_r;                  // [RQ7]
	wire [CMD_W-1:0]  push_cmd  = {push_addr, byte_write_n, dq_in};
	wire              buf_in_ready;
	wire              buf_out_valid;
	wire              buf_out_ready;
	wire [CMD_W-1:0]  buf_out_cmd;

	// ********************************
	// Write buffer
	// ********************************
	// The array has one port; a read in this cycle holds the drain off
	// Limitation: a read overtaking a buffered write to its address sees old data
	wire rd_now_flow = (op_nxt == `SBSI_OP_READ);
	wire rd_now_pipe = (a1_op_r == `SBSI_OP_READ);
	wire rd_busy     = active & (flow ? rd_now_flow : rd_now_pipe);
	assign buf_out_ready = ~sleep_req & ~rd_busy;

	sbsi_fifo #(
		.W     (CMD_W),
		.DEPTH (DEPTH),
		.AW    (`SBSI_FIFO_AW)
	) u_wbuf (
		.ref_clk   (ref_clk),
		.reset_n   (reset_n),
		.in_valid  (push_req),
		.in_ready  (buf_in_ready),
		.in_data   (push_cmd),
		.out_valid (buf_out_valid),
		.out_ready (buf_out_ready),
		.out_data  (buf_out_cmd)
	);

	wire              commit      = buf_out_valid & buf_out_ready;
	wire [ADDR_W-1:0] commit_addr = buf_out_cmd[CMD_W-1 -: ADDR_W];
	wire [LANES-1:0]  commit_be_n = buf_out_cmd[DATA_W +: LANES];
	wire [DATA_W-1:0] commit_data = buf_out_cmd[DATA_W-1:0];

	// ********************************
	// Storage array, one per byte lane
	// ********************************
	wire [DATA_W-1:0] rd_flow_data;
	wire [DATA_W-1:0] rd_pipe_data;

	genvar g;
	generate
		for (g = 0; g < LANES; g = g + 1) begin : g_lane
			reg [LANE_W-1:0] lane_mem [0:WORDS-1];
			// Write completes on the edge itself; no strobe from the host
			always @(posedge ref_clk) begin
				if (commit && !commit_be_n[g]) begin                        // [RQ9] [RQ4]
					lane_mem[commit_addr] <= commit_data[g*LANE_W +: LANE_W];
				end
			end
			assign rd_flow_data[g*LANE_W +: LANE_W] = lane_mem[addr_nxt];
			assign rd_pipe_data[g*LANE_W +: LANE_W] = lane_mem[a1_addr_r];
		end
	endgenerate

	// ********************************
	// Output stage
	// ********************************
	reg               dq_drive_nxt;
	reg  [DATA_W-1:0] dq_out_nxt;

	// Ignored edges keep the last read on the pins
	always @* begin
		dq_drive_nxt = dq_drive_r;
		dq_out_nxt   = dq_out_r;
		if (active) begin                                                   // [RQ17]
			if (flow) begin
				// Array read lands on the same edge that takes the address
				dq_drive_nxt = rd_now_flow;                                 // [RQ6]
				if (rd_now_flow) begin
					dq_out_nxt = rd_flow_data;
				end
			end else begin
				// Access cycle first, then release at the following edge
				dq_drive_nxt = rd_now_pipe;                                 // [RQ5]
				if (rd_now_pipe) begin
					dq_out_nxt = rd_pipe_data;                              // [RQ5]
				end
			end
		end
	end

	always @(posedge ref_clk) begin
		if (!reset_n) begin
			dq_out_r   <= {DATA_W{1'b0}};
			dq_drive_r <= 1'b0;
		end else begin
			dq_out_r   <= dq_out_nxt;
			dq_drive_r <= dq_drive_nxt;
		end
	end

	// ********************************
	// Status
	// ********************************
	// Shadow of the buffer fill level, so the ready output comes from a flop
	reg  [`SBSI_FIFO_AW:0] buf_level_r;
	reg  [`SBSI_FIFO_AW:0] buf_level_nxt;
	reg                    wr_buf_ready_r;
	reg                    write_dropped_nxt;
	wire                   buf_push = push_req & buf_in_ready;

	always @* begin
		buf_level_nxt = buf_level_r;
		if (buf_push && !commit) begin
			buf_level_nxt = buf_level_r + 1'b1;
		end else if (commit && !buf_push) begin
			buf_level_nxt = buf_level_r - 1'b1;
		end
		// Sticky until reset; a write lost to a full buffer is unrecoverable
		write_dropped_nxt = write_dropped_r | (push_req & ~buf_in_ready);
	end

	always @(posedge ref_clk) begin
		if (!reset_n) begin
			buf_level_r     <= {(`SBSI_FIFO_AW+1){1'b0}};
			wr_buf_ready_r  <= 1'b1;
			write_dropped_r <= 1'b0;
		end else begin
			buf_level_r     <= buf_level_nxt;
			wr_buf_ready_r  <= (buf_level_nxt != DEPTH[`SBSI_FIFO_AW:0]);
			write_dropped_r <= write_dropped_nxt;
		end
	end

	assign dq_out        = dq_out_r;
	// Asynchronous overrides must act without waiting for an edge
	assign dq_oe         = dq_drive_r & ~output_en_n & ~sleep_req;          // [RQ2] [RQ3]
	assign power_down    = sleep_req;                                      // [RQ3]
	assign wr_buf_ready  = wr_buf_ready_r;
	assign write_dropped = write_dropped_r;

endmodule // sbsi_core
`default_nettype wire

// [sim/sbsi_host_model.sv]
// Purpose: Host-side strap driver for the burst RAM bench
// Assumes: Mode requests change only while reset is low
// Notes:   Straps latch in reset so they never toggle during traffic
`timescale 1ns/1ns
`default_nettype none
module sbsi_host_model (
	input  wire logic ref_clk,
	input  wire logic reset_n,
	input  wire logic flow_req,
	input  wire logic inter_req,
	output var  logic flow_through_sel_n,
	output var  logic burst_order_sel_n
);
	// ************
	// Mode straps
	// ************
	always @(posedge ref_clk) begin
		if (!reset_n) begin
			flow_through_sel_n <= !flow_req;
			burst_order_sel_n  <= inter_req;
		end
	end
endmodule // sbsi_host_model
`default_nettype wire

// [sim/sbsi_core_properties.sv]
// Purpose: Port-level assertions for sbsi_core
// Assumes: Bound to every sbsi_core instance
// Notes:   Read latency checks look only where output enable is low
`timescale 1ns/1ns
`default_nettype none
module sbsi_core_properties #(
	parameter LANE_W = 9,
	parameter LANES  = 4
) (
	input wire logic                    ref_clk,
	input wire logic                    reset_n,
	input wire logic                    chip_sel_a_n,
	input wire logic                    chip_sel_b,
	input wire logic                    chip_sel_c_n,
	input wire logic                    write_en_n,
	input wire logic                    clock_en_n,
	input wire logic                    burst_advance,
	input wire logic                    output_en_n,
	input wire logic                    sleep_req,
	input wire logic                    flow_through_sel_n,
	input wire logic [LANES*LANE_W-1:0] dq_out,
	input wire logic                    dq_oe,
	input wire logic                    power_down,
	input wire logic                    wr_buf_ready,
	input wire logic                    write_dropped
);
	// ***********
	// Properties
	// ***********
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	wire act = !clock_en_n && !sleep_req;
	wire sel = !chip_sel_a_n && chip_sel_b && !chip_sel_c_n;
	wire nrd = act && !burst_advance && sel && write_en_n;
	wire nod = act && !burst_advance && !(sel && write_en_n);
	oe_gate_a: assert property (output_en_n |-> !dq_oe)
		else $error("Driving with output enable off");
	sleep_pd_a: assert property (power_down == sleep_req && (sleep_req -> !dq_oe))
		else $error("Sleep not applied at once");
	stall_hold_a: assert property (reset_n && !act |=> $stable(dq_out))
		else $error("Output changed on ignored edge");
	pipe_read_a: assert property (nrd && flow_through_sel_n ##1 act ##1 !output_en_n && !sleep_req |-> dq_oe)
		else $error("Pipelined read not driven");
	flow_read_a: assert property (nrd && !flow_through_sel_n ##1 !output_en_n && !sleep_req |-> dq_oe)
		else $error("Flow read not driven");
	pipe_idle_a: assert property (nod && flow_through_sel_n ##1 act |=> !dq_oe)
		else $error("Pipelined drive without read");
	flow_idle_a: assert property (nod && !flow_through_sel_n |=> !dq_oe)
		else $error("Flow drive without read");
	reset_state_a: assert property (@(posedge ref_clk) disable iff (1'b0)
		!reset_n |=> !dq_oe && !write_dropped && wr_buf_ready) else $error("Bad state in reset");
	pipe_c: cover property (nrd && flow_through_sel_n ##1 act ##1 dq_oe);
	flow_c: cover property (nrd && !flow_through_sel_n ##1 dq_oe);
	stall_c: cover property (act ##1 clock_en_n);
endmodule // sbsi_core_properties
bind sbsi_core sbsi_core_properties #(.LANE_W(LANE_W), .LANES(LANES)) props (.ref_clk, .reset_n, .chip_sel_a_n,
	.chip_sel_b, .chip_sel_c_n, .write_en_n, .clock_en_n, .burst_advance, .output_en_n, .sleep_req,
	.flow_through_sel_n, .dq_out, .dq_oe, .power_down, .wr_buf_ready, .write_dropped);
`default_nettype wire

// [sim/sbsi_core_bench.sv]
// Purpose: Self-checking bench for sbsi_core
// Assumes: Each bus call drives values sampled at the next edge
// Notes:   Async checks run on stalled edges so the pipeline and output flops hold
`timescale 1ns/1ns
`default_nettype none
`include "sbsi_consts.vh"
`define SBSI_CMP(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
	$display("Error at %0t: got %h expected %h", $time, g, e); end end
module sbsi_core_bench;
	// *****************
	// Stimulus and DUT
	// *****************
	localparam logic [1:0] RD = `SBSI_OP_READ, WR = `SBSI_OP_WRITE, ID = `SBSI_OP_IDLE, AD = 2'h3;
	localparam logic [35:0] D1 = 36'hA5A5A5A5A, D2 = 36'h123456789, D3 = 36'hFEDCBA987, M = 36'h007FC01FF;
	logic        ref_clk = 1'b0, reset_n = 1'b0, clock_en_n = 1'b0, burst_advance = 1'b0;
	logic        write_en_n = 1'b1, output_en_n = 1'b0, sleep_req = 1'b0, flow_req = 1'b0, inter_req = 1'b0;
	logic [2:0]  sel_d = 3'h0, sel_pat = 3'h2;
	logic [9:0]  address = 10'h0;
	logic [3:0]  byte_write_n = 4'hF;
	logic [35:0] dq_in = 36'h0;
	wire  [35:0] dq_out;
	wire         fts_n, bos_n, dq_oe, power_down, wr_buf_ready, write_dropped;
	int          err_total = 0, checks_done = 0, cyc = 0;
	sbsi_core uut (.ref_clk, .reset_n, .address, .chip_sel_a_n(sel_d[2]), .chip_sel_b(sel_d[1]),
		.chip_sel_c_n(sel_d[0]), .write_en_n, .clock_en_n, .burst_advance, .byte_write_n, .dq_in, .output_en_n,
		.sleep_req, .flow_through_sel_n(fts_n), .burst_order_sel_n(bos_n), .dq_out, .dq_oe, .power_down,
		.wr_buf_ready, .write_dropped);
	sbsi_host_model host (.ref_clk, .reset_n, .flow_req, .inter_req, .flow_through_sel_n(fts_n),
		.burst_order_sel_n(bos_n));
	initial forever #50 ref_clk = ~ref_clk;
	// A hang ends the run as a failure
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 600) begin
			err_total++;
			test_done();
		end
	end
	task automatic test_done();
		$display("Checks %0d, errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic bus(input logic [1:0] k, input logic [9:0] a, input logic [35:0] d, input logic [3:0] be);
		@(posedge ref_clk);
		clock_en_n <= 1'b0;
		address <= a;
		sel_d <= (k == ID) ? 3'h0 : sel_pat;
		write_en_n <= (k != WR);
		burst_advance <= (k == AD);
		dq_in <= d;
		byte_write_n <= be;
		@(negedge ref_clk);
	endtask
	task automatic idle(input int n);
		repeat (n) bus(ID, 10'h0, 36'h0, 4'hF);
	endtask
	task automatic hold(input logic oe_n, input logic zz);
		@(posedge ref_clk);
		clock_en_n <= 1'b1;
		output_en_n <= oe_n;
		sleep_req <= zz;
		@(negedge ref_clk);
	endtask
	task automatic rst(input logic f, input logic i);
		@(posedge ref_clk);
		reset_n <= 1'b0;
		flow_req <= f;
		inter_req <= i;
		repeat (6) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(negedge ref_clk);
		`SBSI_CMP({dq_oe, wr_buf_ready, write_dropped}, 3'b010)
	endtask
	function automatic logic [35:0] beat_val(input logic inter, input int n);
		return 36'h111111111 * (inter ? (1 ^ n) + 1 : (1 + n) % 4 + 1);
	endfunction
	// **********
	// Scenarios
	// **********
	task automatic t_pipe();
		bus(WR, 10'h10, 36'h0, 4'hF);
		bus(WR, 10'h11, 36'h0, 4'hF);
		bus(ID, 10'h0, D1, 4'h0);
		bus(ID, 10'h0, D2, 4'h0);
		idle(2);
		bus(RD, 10'h10, 36'h0, 4'hF);
		bus(WR, 10'h10, 36'h0, 4'hF);
		bus(RD, 10'h11, 36'h0, 4'hF);
		`SBSI_CMP({dq_oe, dq_out}, {1'b1, D1})
		bus(ID, 10'h0, D3, 4'hA);
		idle(1);
		`SBSI_CMP({dq_oe, dq_out}, {1'b1, D2})
		idle(2);
		bus(RD, 10'h10, 36'h0, 4'hF);
		idle(2);
		`SBSI_CMP(dq_out, (D3 & M) | (D1 & ~M))
	endtask
	task automatic t_burst(input logic inter);
		int j;
		for (j = 0; j < 6; j++) begin
			bus(j < 4 ? WR : ID, 10'h30 + 10'(j), j > 1 ? 36'h111111111 * (j - 1) : 36'h0, j > 1 ? 4'h0 : 4'hF);
		end
		idle(2);
		bus(RD, 10'h31, 36'h0, 4'hF);
		bus(AD, 10'h0, 36'h0, 4'hF);
		bus(AD, 10'h0, 36'h0, 4'hF);
		`SBSI_CMP(dq_out, beat_val(inter, 0))
		bus(AD, 10'h0, 36'h0, 4'hF);
		`SBSI_CMP(dq_out, beat_val(inter, 1))
		hold(1'b1, 1'b0);
		`SBSI_CMP(dq_oe, 1'b0)
		hold(1'b0, 1'b1);
		`SBSI_CMP({power_down, dq_oe}, 2'b10)
		hold(1'b0, 1'b0);
		`SBSI_CMP({dq_oe, dq_out}, {1'b1, beat_val(inter, 2)})
		idle(2);
		`SBSI_CMP(dq_out, beat_val(inter, 3))
	endtask
	task automatic t_sel();
		int i;
		for (i = 0; i < 3; i++) begin
			sel_pat = 3'h2 ^ (3'h1 << i);
			bus(RD, 10'h31, 36'h0, 4'hF);
			idle(2);
			`SBSI_CMP(dq_oe, 1'b0)
		end
		sel_pat = 3'h2;
	endtask
	task automatic t_flow();
		bus(WR, 10'h20, 36'h0, 4'hF);
		bus(RD, 10'h33, D1, 4'h0);
		idle(1);
		`SBSI_CMP({dq_oe, dq_out}, {1'b1, 36'h444444444})
		idle(1);
		bus(RD, 10'h20, 36'h0, 4'hF);
		idle(1);
		`SBSI_CMP(dq_out, D1)
		bus(WR, 10'h24, 36'h0, 4'hF);
		bus(AD, 10'h0, D2, 4'h0);
		bus(ID, 10'h0, D3, 4'h0);
		idle(1);
		bus(RD, 10'h25, 36'h0, 4'hF);
		idle(1);
		`SBSI_CMP(dq_out, D3)
	endtask
	initial begin
		rst(1'b0, 1'b0);
		t_pipe();
		t_burst(1'b0);
		t_sel();
		rst(1'b0, 1'b1);
		t_burst(1'b1);
		rst(1'b1, 1'b0);
		t_flow();
		test_done();
	end
endmodule // sbsi_core_bench
`default_nettype wire
